/* hw/vfrm_consts.vh */
`ifndef VFRM_CONSTS_VH
`define VFRM_CONSTS_VH
// Register addresses (16-bit register numbers, each 32-bit value spans two)
`define VFRM_ADDR_NOW        16'h4a00
`define VFRM_ADDR_DISPLAY    16'h4a02
`define VFRM_ADDR_FREQ       16'h4a04
`define VFRM_ADDR_LOOP       16'h4a06
`define VFRM_ADDR_UPPER      16'h6a00
`define VFRM_ADDR_LOWER      16'h6a02
`define VFRM_ADDR_PERSIST    16'h6a04
// Reset values: IEEE-754 near +/-3.4E38 (largest finite) and three cycles
`define VFRM_UPPER_RST       32'h7f7fffff
`define VFRM_LOWER_RST       32'hff7fffff
`define VFRM_PERSIST_RST     32'h00000003
`define VFRM_FLOAT_ZERO      32'h00000000
// Soft fault flag position
`define VFRM_SOFT_RANGE_BIT  9
// Evaluation cycle is one per four sensor periods
`define VFRM_EVAL_DIV        2'h3
`endif

/* hw/vfrm_volume_flow_range_monitor.v */
// What this block does
// - Raise soft fault bit 9 when flow exceeds the upper limit persistently.
// - Raise soft fault bit 9 when flow is below the lower limit persistently.
// - Limits span about -3.4E38..3.4E38; upper defaults top, lower defaults bottom.
// - Warn only after threshold consecutive cycles; one cycle is four sensor periods.
// - Persistence threshold is an unsigned 32-bit count, default three.
// - Present current volume flow as a 32-bit float input register.
// - Present the display-filtered copy of volume flow.
// - Present the frequency-output-filtered copy of volume flow.
// - Present the control-loop-filtered copy of volume flow.
// - Limits and threshold are writable only with service-level access.
// - Volume flow is forced to zero when no valid density exists.
`timescale 1ns/1ns
`default_nettype none
`include "vfrm_consts.vh"

module vfrm_volume_flow_range_monitor (
  input  wire        clk,
  input  wire        rstn,
  input  wire        sensorTick,
  input  wire        densityValid,
  input  wire [31:0] flowNow,
  input  wire [31:0] flowDisplay,
  input  wire [31:0] flowFreqOut,
  input  wire [31:0] flowLoop,
  input  wire        serviceAccess,
  input  wire        regRead,
  input  wire        regWrite,
  input  wire [15:0] regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  output reg         regAck,
  output reg         regExc,
  output reg         rangeFault
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  // Flow copies are not latched: a read returns the value present at the request edge
  reg [31:0] upperLimit_r;
  reg [31:0] lowerLimit_r;
  reg [31:0] persistCount_r;
  reg [31:0] violCount_r;
  reg [1:0]  tickDiv_r;
  reg        evalTick;
  reg [31:0] flowNowQ;
  reg [31:0] flowDispQ;
  reg [31:0] flowFreqQ;
  reg [31:0] flowLoopQ;

  // Density loss zeroes every published flow copy
  always @*
  begin
    flowNowQ  = densityValid ? flowNow     : `VFRM_FLOAT_ZERO;
    flowDispQ = densityValid ? flowDisplay : `VFRM_FLOAT_ZERO;
    flowFreqQ = densityValid ? flowFreqOut : `VFRM_FLOAT_ZERO;
    flowLoopQ = densityValid ? flowLoop    : `VFRM_FLOAT_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Float ordering: returns 1 when a > b, NaN never compares greater
  function fGreater;
    input [31:0] a;
    input [31:0] b;
    reg          aNan;
    reg          bNan;
    reg          bothZero;
    begin
      aNan = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
      bNan = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
      bothZero = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
      if (aNan || bNan || bothZero)
        fGreater = 1'b0;
      else if (a[31] != b[31])
        fGreater = b[31];
      else if (!a[31])
        fGreater = a[30:0] > b[30:0];
      else
        fGreater = a[30:0] < b[30:0];
    end
  endfunction

  wire aboveMax = fGreater(flowNowQ, upperLimit_r);
  wire belowMin = fGreater(lowerLimit_r, flowNowQ);
  wire outRange = aboveMax | belowMin;

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation enable: one pulse per four sensor ticks
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      tickDiv_r <= 2'h0;
      evalTick  <= 1'b0;
    end
    else
    begin
      evalTick <= 1'b0;
      if (sensorTick)
      begin
        tickDiv_r <= tickDiv_r + 2'h1;
        evalTick  <= (tickDiv_r == `VFRM_EVAL_DIV);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault integrator; counter saturates so a huge threshold never wraps
  // A threshold of zero or one both fault on the first out-of-range evaluation
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      violCount_r <= 32'h0;
      rangeFault  <= 1'b0;
    end
    else if (evalTick)
    begin
      if (outRange)
      begin
        if (violCount_r != 32'hffffffff)
          violCount_r <= violCount_r + 32'h1;
        if ((violCount_r + 32'h1) >= persistCount_r || violCount_r == 32'hffffffff)
          rangeFault <= 1'b1;
      end
      else
      begin
        violCount_r <= 32'h0;
        rangeFault  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access: high word at even address, low word at odd address
  wire [15:0] baseAddr = {regAddr[15:1], 1'b0};
  wire        loWord   = regAddr[0];
  wire        isHold   = (baseAddr == `VFRM_ADDR_UPPER) || (baseAddr == `VFRM_ADDR_LOWER)
                         || (baseAddr == `VFRM_ADDR_PERSIST);
  reg  [31:0] rdWord;
  reg         rdHit;

  always @*
  begin
    rdHit = 1'b1;
    case (baseAddr)
      `VFRM_ADDR_NOW:     rdWord = flowNowQ;
      `VFRM_ADDR_DISPLAY: rdWord = flowDispQ;
      `VFRM_ADDR_FREQ:    rdWord = flowFreqQ;
      `VFRM_ADDR_LOOP:    rdWord = flowLoopQ;
      `VFRM_ADDR_UPPER:   rdWord = upperLimit_r;
      `VFRM_ADDR_LOWER:   rdWord = lowerLimit_r;
      `VFRM_ADDR_PERSIST: rdWord = persistCount_r;
      default:
      begin
        rdWord = 32'h0;
        rdHit  = 1'b0;
      end
    endcase
  end

  // Writes land per 16-bit half; without service access they are refused
  // Limitation: a limit is compared as a mixed pair until its second half lands
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      upperLimit_r   <= `VFRM_UPPER_RST;
      lowerLimit_r   <= `VFRM_LOWER_RST;
      persistCount_r <= `VFRM_PERSIST_RST;
      regRdata       <= 16'h0;
      regAck         <= 1'b0;
      regExc         <= 1'b0;
    end
    else
    begin
      regAck <= 1'b0;
      regExc <= 1'b0;
      if (regWrite)
      begin
        if (isHold && serviceAccess)
        begin
          regAck <= 1'b1;
          if (baseAddr == `VFRM_ADDR_UPPER)
          begin
            if (loWord)
              upperLimit_r[15:0] <= regWdata;
            else
              upperLimit_r[31:16] <= regWdata;
          end
          if (baseAddr == `VFRM_ADDR_LOWER)
          begin
            if (loWord)
              lowerLimit_r[15:0] <= regWdata;
            else
              lowerLimit_r[31:16] <= regWdata;
          end
          if (baseAddr == `VFRM_ADDR_PERSIST)
          begin
            if (loWord)
              persistCount_r[15:0] <= regWdata;
            else
              persistCount_r[31:16] <= regWdata;
          end
        end
        else
          regExc <= 1'b1;
      end
      else if (regRead)
      begin
        regRdata <= loWord ? rdWord[15:0] : rdWord[31:16];
        regAck   <= rdHit;
        regExc   <= !rdHit;
      end
    end
  end

endmodule // vfrm_volume_flow_range_monitor
`default_nettype wire

/* bench/vfrm_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module vfrm_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sensorTick,
  input wire logic        serviceAccess,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regRdata,
  input wire logic        regAck,
  input wire logic        regExc,
  input wire logic        rangeFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Request, then exactly one answer a cycle later
  sequence s_req; regRead || regWrite; endsequence
  sequence s_answer; ##1 (regAck ^ regExc); endsequence
  a_req_answered: assert property (s_req |-> s_answer) else $error("request not answered");
  a_idle_silent: assert property (!(regRead || regWrite) |=> !(regAck || regExc))
    else $error("answer without request");
  a_locked_refused: assert property (regWrite && !serviceAccess |=> regExc)
    else $error("write accepted without service access");
  a_input_refused: assert property (regWrite && regAddr[15:12] == 4'h4 |=> regExc)
    else $error("write to input register accepted");
  a_fault_rise_eval: assert property ($rose(rangeFault) |-> $past(sensorTick, 2))
    else $error("fault rose off an evaluation");
  a_fault_fall_eval: assert property ($fell(rangeFault) |-> $past(sensorTick, 2))
    else $error("fault fell off an evaluation");
  a_ack_exclusive: assert property (!(regAck && regExc)) else $error("ack and refusal together");
  a_service_write_ok: assert property (regWrite && serviceAccess
    && regAddr[15:3] == 13'h0d40 && regAddr[2:0] < 3'h6 |=> regAck)
    else $error("service write to limit not accepted");
  a_input_read_ok: assert property (regRead && !regWrite && regAddr[15:3] == 13'h0940
    |=> regAck)
    else $error("read of flow register not accepted");
  a_rdata_held: assert property (!regRead |=> $stable(regRdata)) else $error("read data moved");
endmodule // vfrm_asserts
bind vfrm_volume_flow_range_monitor vfrm_asserts u_chk (.clk(clk), .rstn(rstn),
  .sensorTick(sensorTick), .serviceAccess(serviceAccess), .regRead(regRead),
  .regWrite(regWrite), .regAddr(regAddr), .regRdata(regRdata), .regAck(regAck),
  .regExc(regExc), .rangeFault(rangeFault));
`default_nettype wire

/* bench/vfrm_master.sv */
`timescale 1ns/1ns
`default_nettype none
module vfrm_master (
  input  wire logic        clk,
  input  wire logic [15:0] regRdata,
  input  wire logic        regExc,
  output var  logic        regRead = 1'b0,
  output var  logic        regWrite = 1'b0,
  output var  logic [15:0] regAddr = 16'h0000,
  output var  logic [15:0] regWdata = 16'h0000,
  output var  logic        serviceAccess = 1'b0
);
  // Service level must be obtained before limits can change
  task grant(input logic on);
    @(posedge clk);
    serviceAccess <= on;
  endtask
  // Strobe for one edge, then take the registered answer
  task xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e);
    @(posedge clk);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= ~a; // Released lines must not look valid
    regWdata <= ~d;
    // The registered answer is taken at the edge where it is sampled high
    @(posedge clk);
    q = regRdata;
    e = regExc;
  endtask
endmodule // vfrm_master
`default_nettype wire

/* bench/vfrm_volume_flow_range_monitor_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module vfrm_volume_flow_range_monitor_tb;
  logic clk = 1'b0, rstn = 1'b0, sensorTick = 1'b0, densityValid = 1'b1, e;
  logic [31:0] flowNow = 32'h12345678, flowDisplay = 32'h9abcdef0;
  logic [31:0] flowFreqOut = 32'h0f1e2d3c, flowLoop = 32'h4b5a6978;
  logic [15:0] q;
  logic [95:0] limRst = 96'h7f7fffff_ff7fffff_00000003;
  wire logic [127:0] flows = {flowNow, flowDisplay, flowFreqOut, flowLoop};
  wire logic [15:0] regAddr, regWdata, regRdata;
  wire logic regRead, regWrite, serviceAccess, regAck, regExc, rangeFault;
  int failures = 0, comparisons = 0;
  always #10 clk = ~clk;
  vfrm_master m (.clk(clk), .regRdata(regRdata), .regExc(regExc), .regRead(regRead),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .serviceAccess(serviceAccess));
  vfrm_volume_flow_range_monitor dut (.clk(clk), .rstn(rstn), .sensorTick(sensorTick),
    .densityValid(densityValid), .flowNow(flowNow), .flowDisplay(flowDisplay),
    .flowFreqOut(flowFreqOut), .flowLoop(flowLoop), .serviceAccess(serviceAccess),
    .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regAck(regAck), .regExc(regExc), .rangeFault(rangeFault));
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [15:0] a, input logic [15:0] x);
    m.xfer(1'b0, a, 16'h0000, q, e);
    chk({16'h0000, q}, {16'h0000, x});
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d, input logic x);
    m.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, x});
  endtask
  // Whole groups of four ticks keep the evaluation phase aligned
  task run(input int n, input logic [31:0] f, input logic x);
    @(posedge clk);
    flowNow <= f;
    repeat (n)
    begin
      @(posedge clk);
      sensorTick <= 1'b1;
      @(posedge clk);
      sensorTick <= 1'b0;
    end
    repeat (3) @(posedge clk);
    chk({31'h0, rangeFault}, {31'h0, x});
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(16'h6a00 + i[15:0], limRst[80 - 16 * i +: 16]);
    for (int i = 0; i < 8; i++) rd(16'h4a00 + i[15:0], flows[112 - 16 * i +: 16]);
    densityValid <= 1'b0;
    for (int i = 0; i < 8; i++) rd(16'h4a00 + i[15:0], 16'h0000);
    densityValid <= 1'b1;
    rd(16'h5000, 16'h0000);
    chk({31'h0, e}, 32'h1);
    wr(16'h6a00, 16'h0000, 1'b1);
    rd(16'h6a00, 16'h7f7f);
    m.grant(1'b1);
    wr(16'h4a00, 16'h0000, 1'b1);
    $display("registers test done");
    wr(16'h6a00, 16'h3f80, 1'b0);
    wr(16'h6a01, 16'h0000, 1'b0);
    run(8, 32'h40000000, 1'b0);
    run(4, 32'h40000000, 1'b1);
    run(4, 32'h3f800000, 1'b0);
    wr(16'h6a02, 16'h3f80, 1'b0);
    wr(16'h6a03, 16'h0000, 1'b0);
    run(8, 32'h3f000000, 1'b0);
    run(4, 32'h3f800000, 1'b0);
    run(8, 32'h3f000000, 1'b0);
    run(4, 32'h3f000000, 1'b1);
    wr(16'h6a05, 16'h0001, 1'b0);
    run(4, 32'h3f800000, 1'b0);
    run(4, 32'h3f000000, 1'b1);
    $display("range test done");
    print_verdict();
  end
endmodule // vfrm_volume_flow_range_monitor_tb
`default_nettype wire
